// ### logic/mne_exec.sv
/*
 * Executes move-file, load-literal, store-accumulator, no-operation and
 * return-from-interrupt. Assumes the file register read port answers
 * combinationally for file_raddr, and that the stack pops on flow.pop.
 */
`timescale 1ns/1ps
module mne_exec (
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire logic                       clk_en,
    input  wire logic                       insn_valid,
    input  wire logic [mne_pkg::INSN_W-1:0] insn,
    input  wire logic [mne_pkg::DATA_W-1:0] file_rdata,
    input  wire logic [mne_pkg::PC_W-1:0]   stack_top,
    output logic      [mne_pkg::FADDR_W-1:0] file_raddr,
    output mne_pkg::mne_fwrite_t             file_wr,
    output mne_pkg::mne_flow_t               flow,
    output logic      [mne_pkg::DATA_W-1:0] acc,
    output logic                            zero_flag,
    output logic                            global_irq_enable,
    output logic                            busy,
    output logic                            illegal
);
    import mne_pkg::*;

    // Field widths worked out from the bit positions
    localparam int unsigned OP6_W = OP_HI - OP6_LO + 1;
    localparam int unsigned OP2_W = OP_HI - OP2_LO + 1;
    localparam int unsigned SUB_W = LIT_SUB_HI - LIT_SUB_LO + 1;

    // Store, no-operation and return share an all-clear top opcode
    function automatic logic top_clear(input logic [INSN_W-1:0] word);
        return word[OP_HI:OP6_LO] == OP_ZERO6;
    endfunction

    // Zero test behind the zero flag
    function automatic logic all_zero(input logic [DATA_W-1:0] value);
        return value == ZERO8;
    endfunction

    mne_state_t state;
    mne_state_t next_state;

    // Registers behind the packed outputs
    logic                wr_we;
    logic [FADDR_W-1:0]  wr_addr;
    logic [DATA_W-1:0]   wr_data;
    logic                rfi_pulse;
    logic [PC_W-1:0]     pc_hold;

    // Instruction fields
    wire logic [OP6_W-1:0]   op6     = insn[OP_HI:OP6_LO];
    wire logic [OP2_W-1:0]   op2     = insn[OP_HI:OP2_LO];
    wire logic [SUB_W-1:0]   lit_sub = insn[LIT_SUB_HI:LIT_SUB_LO];
    wire logic [DATA_W-1:0]  low     = insn[LIT_HI:0];
    wire logic [FADDR_W-1:0] faddr   = insn[FADDR_HI:0];
    wire logic               dest    = insn[DEST_BIT];

    // An instruction is taken only outside the reload slot
    wire logic go = insn_valid && (state == MNE_EXEC);

    // Decode of the five instructions; anything else is flagged
    wire logic is_move  = go && (op6 == OP_MOVE_FILE);
    wire logic is_lit   = go && (op2 == OP_LITERAL)
                        && (lit_sub == LIT_SUB);
    wire logic is_store = go && top_clear(insn) && dest;
    wire logic is_nop   = go && top_clear(insn) && !dest
                        && ((low & NOP_MASK) == NOP_VAL);
    wire logic is_rfi   = go && top_clear(insn) && (low == LOW_RETFI);
    wire logic is_ill   = go
                        && !(is_move || is_lit || is_store || is_nop || is_rfi);

    // Destination select of the move
    wire logic move_acc  = is_move && !dest;
    wire logic move_file = is_move && dest;

    // Next values; the zero flag changes only on a move
    wire logic [DATA_W-1:0] next_acc = is_lit   ? low
                                     : move_acc ? file_rdata : acc;
    wire logic next_zero = is_move ? all_zero(file_rdata) : zero_flag;
    wire logic next_we   = move_file || is_store;
    wire logic [DATA_W-1:0] next_wdata = is_store ? acc : file_rdata;
    wire logic next_gie  = is_rfi ? 1'b1 : global_irq_enable;

    // Read address must be same-cycle, so it cannot wait for a flop
    always_comb begin
        file_raddr = faddr;
    end

    // Return-from-interrupt spends one extra slot on the reload
    always_comb begin
        unique case (state)
            MNE_EXEC: begin
                next_state = is_rfi ? MNE_RELOAD : MNE_EXEC;
            end
            MNE_RELOAD: begin
                next_state = MNE_EXEC;
            end
            default: begin
                next_state = MNE_EXEC;
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= MNE_EXEC;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // Working register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acc <= ZERO8;
        end else if (clk_en) begin
            acc <= next_acc;
        end
    end

    // Zero flag
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            zero_flag <= 1'b0;
        end else if (clk_en) begin
            zero_flag <= next_zero;
        end
    end

    // Pulse for a word that is none of the five
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            illegal <= 1'b0;
        end else if (clk_en) begin
            illegal <= is_ill;
        end
    end

    // High during the reload slot
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
        end else if (clk_en) begin
            busy <= is_rfi;
        end
    end

    // Local stand-in for the enable bit; only reset clears it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            global_irq_enable <= 1'b0;
        end else if (clk_en) begin
            global_irq_enable <= next_gie;
        end
    end

    // File write strobe
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_we <= 1'b0;
        end else if (clk_en) begin
            wr_we <= next_we;
        end
    end

    // File write address
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_addr <= '0;
        end else if (clk_en) begin
            wr_addr <= faddr;
        end
    end

    // File write data
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_data <= ZERO8;
        end else if (clk_en) begin
            wr_data <= next_wdata;
        end
    end

    // Pop and program counter load travel together
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rfi_pulse <= 1'b0;
        end else if (clk_en) begin
            rfi_pulse <= is_rfi;
        end
    end

    // Stack top captured for the reload
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pc_hold <= '0;
        end else if (clk_en) begin
            pc_hold <= stack_top;
        end
    end

    // Packed outputs carry flop values only
    assign file_wr = '{we: wr_we, addr: wr_addr, data: wr_data};
    assign flow    = '{pop: rfi_pulse, pc: pc_hold, pc_load: rfi_pulse};

endmodule // mne_exec

// ### pkg/mne_pkg.sv
/*
 * Package for the move / no-operation / interrupt-return executor:
 * opcode patterns, field positions, widths and the packed carriers.
 * Assumes a 14-bit instruction word and an 8-bit data path.
 */
package mne_pkg;
    localparam int unsigned INSN_W      = 14;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned FADDR_W     = 7;
    localparam int unsigned PC_W        = 13;
    localparam int unsigned GIE_BIT     = 7;

    // Opcode fields
    localparam int unsigned OP_HI       = 13;
    localparam int unsigned OP6_LO      = 8;
    localparam int unsigned OP2_LO      = 12;
    localparam int unsigned DEST_BIT    = 7;
    localparam int unsigned LIT_HI      = 7;
    localparam int unsigned FADDR_HI    = 6;

    localparam logic [5:0]  OP_MOVE_FILE = 6'h08;
    localparam logic [5:0]  OP_ZERO6     = 6'h00;
    localparam logic [1:0]  OP_LITERAL   = 2'h3;
    localparam logic [1:0]  LIT_SUB      = 2'h0;
    localparam int unsigned LIT_SUB_HI   = 11;
    localparam int unsigned LIT_SUB_LO   = 10;
    localparam logic [7:0]  LOW_RETFI    = 8'h09;
    // NO_OPERATION low byte is 0xx0_0000: bits 6:5 are don't care
    localparam logic [7:0]  NOP_MASK     = 8'h9f;
    localparam logic [7:0]  NOP_VAL      = 8'h00;
    localparam logic [7:0]  ZERO8        = 8'h00;

    typedef enum logic [2:0] {
        MNE_EXEC   = 3'b001,
        MNE_RELOAD = 3'b010,
        MNE_IDLE   = 3'b100
    } mne_state_t;

    typedef struct packed {
        logic               we;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0]  data;
    } mne_fwrite_t;

    typedef struct packed {
        logic            pop;
        logic [PC_W-1:0] pc;
        logic            pc_load;
    } mne_flow_t;
endpackage

// ### verif/mne_exec_checker.sv
/* Assertions for mne_exec. Assumes clk_en stays high on the edge after a return. */
`timescale 1ns/1ps
module mne_exec_checker (
    input logic clock, rst, clk_en, insn_valid, busy, zero_flag, global_irq_enable, illegal,
    input logic [13:0] insn,
    input logic [7:0]  file_rdata, acc,
    input logic [12:0] stack_top,
    input logic [6:0]  file_raddr,
    input mne_pkg::mne_fwrite_t file_wr,
    input mne_pkg::mne_flow_t   flow
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire tk  = clk_en && insn_valid && !busy;
    wire mv  = tk && insn[13:8] == 6'h08;
    wire ret = tk && insn == 14'h0009;
    wire known = mv || ret || (tk && insn[13:10] == 4'hc) || (tk && insn[13:7] == 7'h01)
        || (tk && (insn & 14'h3f9f) == 14'h0000);
    property p_ill; tk && !known |=> illegal; endproperty
    a_ill: assert property (p_ill) else $error("unknown word not flagged");
    property p_quiet; clk_en && !tk |=> !illegal && !file_wr.we && !flow.pop; endproperty
    a_quiet: assert property (p_quiet) else $error("output without instruction");
    c_ill: cover property (tk && !known);
    property p_mv_acc; mv && !insn[7] |=> acc == $past(file_rdata); endproperty
    a_mv_acc: assert property (p_mv_acc) else $error("move to acc");
    property p_mv_wr; mv && insn[7] |=> file_wr.we && file_wr.data == $past(file_rdata);
    endproperty
    a_mv_wr: assert property (p_mv_wr) else $error("move write back");
    property p_mv_z; mv |=> zero_flag == ($past(file_rdata) == 8'h00); endproperty
    a_mv_z: assert property (p_mv_z) else $error("move zero flag");
    property p_lit; tk && insn[13:10] == 4'hc |=> acc == $past(insn[7:0]) && $stable(zero_flag);
    endproperty
    a_lit: assert property (p_lit) else $error("literal load");
    property p_ret; ret |=> flow.pop && flow.pc_load && flow.pc == $past(stack_top)
        && global_irq_enable && $stable(zero_flag); endproperty
    a_ret: assert property (p_ret) else $error("return pop");
    property p_slot; ret |=> busy ##1 !busy && !flow.pop; endproperty
    a_slot: assert property (p_slot) else $error("return length");
    property p_st; tk && insn[13:7] == 7'h01 |=> file_wr.we && file_wr.data == $past(acc);
    endproperty
    a_st: assert property (p_st) else $error("store acc");
    property p_nop; tk && (insn & 14'h3f9f) == 14'h0000 |=> !file_wr.we && $stable(acc);
    endproperty
    a_nop: assert property (p_nop) else $error("no operation");
    c_mv: cover property (mv && insn[7]);
    c_lit: cover property (tk && insn[13:10] == 4'hc);
    c_ret: cover property (ret ##2 !busy);
endmodule // mne_exec_checker
bind mne_exec mne_exec_checker chk_inst (.*);

// ### verif/mne_exec_tb.sv
/* Bench for mne_exec. Assumes the checker is bound to the design. */
`timescale 1ns/1ps
module mne_exec_tb;
    import mne_pkg::*;
    logic        clock = 0, rst = 1, insn_valid = 0, clk_en = 1;
    logic [13:0] insn = 14'h0000;
    logic [7:0]  file_rdata = 8'h00, acc;
    logic [12:0] stack_top = 13'h1abc;
    logic [6:0]  file_raddr;
    logic        zero_flag, global_irq_enable, busy, illegal;
    mne_fwrite_t file_wr;
    mne_flow_t   flow;
    int          mismatches = 0, checks_done = 0, cycles = 0;
    always #2 clock = ~clock;
    mne_exec mne_exec_inst (
        .clock             (clock),
        .rst               (rst),
        .clk_en            (clk_en),
        .insn_valid        (insn_valid),
        .insn              (insn),
        .file_rdata        (file_rdata),
        .stack_top         (stack_top),
        .file_raddr        (file_raddr),
        .file_wr           (file_wr),
        .flow              (flow),
        .acc               (acc),
        .zero_flag         (zero_flag),
        .global_irq_enable (global_irq_enable),
        .busy              (busy),
        .illegal           (illegal)
    );
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic issue(logic [13:0] w, logic [7:0] rd);
        @(negedge clock);
        {insn, file_rdata, insn_valid} = {w, rd, 1'b1};
        @(negedge clock);
        insn_valid = 0;
    endtask
    task automatic t_move();
        issue(14'h0810, 8'ha5);
        chk("raddr", 16'h0010, {9'h000, file_raddr});
        chk("acc", {8'h00, 8'ha5, 8'h00}, {acc, 7'h00, zero_flag});
        issue(14'h0890, 8'h00);
        chk("wr", {1'b1, 7'h10, 8'h00}, {file_wr.we, file_wr.addr, file_wr.data});
        chk("zero", 16'h0001, {15'h0000, zero_flag});
    endtask
    task automatic t_lit();
        for (int b = 0; b < 4; b++) begin
            issue({4'hc, b[1:0], 8'h5a ^ 8'(b)}, 8'h00);
            chk("lit", {7'h00, 8'h5a ^ 8'(b), 1'b1}, {7'h00, acc, zero_flag});
        end
    endtask
    task automatic t_store();
        issue(14'h00ff, 8'h00);
        chk("st", {1'b1, 7'h7f, 8'h59}, {file_wr.we, file_wr.addr, file_wr.data});
        for (int b = 0; b < 4; b++) begin
            issue({7'h00, b[1:0], 5'h00}, 8'hff);
            chk("nop", {7'h00, 8'h59, 1'b0}, {7'h00, acc, file_wr.we});
        end
    endtask
    task automatic t_ret();
        @(negedge clock);
        {insn, insn_valid} = {14'h0009, 1'b1};
        @(negedge clock);
        insn = {4'hc, 2'b00, 8'h33};
        chk("pc", {1'b1, 13'h1abc, 1'b1, 1'b1}, {flow, global_irq_enable});
        chk("busy", 16'h0003, {14'h0000, busy, zero_flag});
        @(negedge clock);
        insn_valid = 0;
        chk("slot", 16'h0059, {6'h00, busy, flow.pop, acc});
    endtask
    task automatic t_misc();
        @(negedge clock);
        clk_en = 0;
        issue({4'hc, 2'b00, 8'h33}, 8'h00);
        chk("freeze", 16'h0059, {8'h00, acc});
        clk_en = 1;
        issue(14'h0008, 8'h00);
        chk("ill", 16'h0159, {6'h00, flow.pop, illegal, acc});
        @(negedge clock);
        rst = 1;
        @(negedge clock);
        chk("reset", 16'h0000, {acc, 4'h0, zero_flag, global_irq_enable, busy, illegal});
        rst = 0;
        issue({4'hc, 2'b11, 8'h12}, 8'h00);
        chk("relit", 16'h0012, {7'h00, zero_flag, acc});
    endtask
    task automatic finish_test();
        if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clock) if (++cycles > 500) begin
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge clock);
        @(negedge clock) rst = 0;
        t_move();
        t_lit();
        t_store();
        t_ret();
        t_misc();
        finish_test();
    end
endmodule // mne_exec_tb
